// [rtl/ccd_defs.svh]
`ifndef CCD_DEFS_SVH
`define CCD_DEFS_SVH

// Register bus
`define CCD_ADDR_W        4
`define CCD_DATA_W        16
`define CCD_ADDR_RSVD     4'h5
`define CCD_ADDR_CFG      4'h6
`define CCD_ADDR_THR      4'h7
`define CCD_ADDR_STAT     4'hE
`define CCD_ADDR_MASK     4'hF
`define CCD_RD_ZERO       16'h0000

// Reset values
`define CCD_RST_RSVD      16'h0000
`define CCD_RST_CFG       16'h0600
`define CCD_RST_THR       16'h0000
`define CCD_RST_EVT       2'h0

// Event bits in status and mask
`define CCD_EVT_W         2
`define CCD_EVT_DETECT    0
`define CCD_EVT_WINDOW    1

// Conversion data
`define CCD_NCH           3
`define CCD_RES_W         24
`define CCD_THR_PAD       8'h00

// Counter widths and seeds
`define CCD_SETTLE_W      17
`define CCD_SETTLE_BASE   17'h0_0002
`define CCD_SETTLE_ONE    17'h0_0001
`define CCD_WIN_W         12
`define CCD_WIN_ONE       12'h001
`define CCD_HITS_W        8
`define CCD_HITS_BASE     8'h01

// Measurement window lengths in conversion periods
`define CCD_LEN_0         12'h080
`define CCD_LEN_1         12'h100
`define CCD_LEN_2         12'h200
`define CCD_LEN_3         12'h300
`define CCD_LEN_4         12'h500
`define CCD_LEN_5         12'h700
`define CCD_LEN_6         12'hA00
`define CCD_LEN_7         12'hE00

`endif

// [rtl/ccd_pkg.sv]
`include "ccd_defs.svh"

package ccd_pkg;

    typedef enum logic [3:0] {
        CCD_IDLE    = 4'b0001,
        CCD_SETTLE  = 4'b0010,
        CCD_MEASURE = 4'b0100,
        CCD_DONE    = 4'b1000
    } ccd_state_t;

    typedef struct packed {
        logic [2:0] reserved;
        logic [3:0] chop_settle_delay;
        logic       chop_enable;
        logic       detect_all_channels;
        logic [2:0] detect_hit_count;
        logic [2:0] detect_window_length;
        logic       detect_enable;
    } ccd_cfg_t;

    typedef struct packed {
        logic                                  valid;
        logic [`CCD_NCH-1:0][`CCD_RES_W-1:0]   data;
    } ccd_conv_t;

endpackage

// [rtl/ccd_down_counter.sv]
`timescale 1ns/1ps
`include "ccd_defs.svh"

module ccd_down_counter #(
    parameter int W = 8
) (
    input  wire logic         clk_i,    // System clock
    input  wire logic         rst_n_i,  // Async reset, active low
    input  wire logic         load_i,   // Load start value
    input  wire logic [W-1:0] value_i,  // Start value
    input  wire logic         dec_i,    // Count one down
    output logic      [W-1:0] count_o,  // Current count
    output logic              zero_o    // Count is zero
);

    logic [W-1:0] count;

    // Load wins over decrement; stops at zero
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count <= '0;
        end else if (load_i) begin
            count <= value_i;
        end else if (dec_i && (count != '0)) begin
            count <= count - {{(W-1){1'b0}}, 1'b1};
        end
    end

    assign count_o = count;
    assign zero_o  = (count == '0);

endmodule

// [rtl/ccd_config_top.sv]
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`include "ccd_defs.svh"

module ccd_config_top (
    input  wire logic                   MCLK_I,      // 50 MHz clock
    input  wire logic                   RESET_N_I,   // Async reset, low
    input  wire logic [`CCD_ADDR_W-1:0] ADDR_I,      // Register address
    input  wire logic [`CCD_DATA_W-1:0] WDATA_I,     // Write data
    input  wire logic                   WR_I,        // Write strobe
    input  wire logic                   RD_I,        // Read strobe
    output logic      [`CCD_DATA_W-1:0] RDATA_O,     // Read data, next cycle
    input  wire logic                   MOD_TICK_I,  // Modulator clock enable
    input  wire ccd_pkg::ccd_conv_t     CONV_I,      // Conversion results
    output logic                        IRQ_O,       // Interrupt level
    output logic                        DETECT_O,    // Detection pulse
    output logic                        CHOP_ENABLE_O, // Global chop on
    output logic                        MEASURING_O  // Window running
);

    logic [`CCD_DATA_W-1:0]  rsvd_word;
    ccd_pkg::ccd_cfg_t       cfg;
    logic [`CCD_DATA_W-1:0]  thr_high;
    logic [`CCD_EVT_W-1:0]   status;
    logic [`CCD_EVT_W-1:0]   mask;
    logic [`CCD_EVT_W-1:0]   next_status;
    logic [`CCD_DATA_W-1:0]  rdata;
    logic                    irq;
    logic                    detect;
    logic                    measuring;

    ccd_pkg::ccd_state_t     state;
    ccd_pkg::ccd_state_t     next_state;
    logic                    load_settle;
    logic                    load_win;
    logic                    win_end;
    logic                    detect_ev;
    logic                    conv_take;
    logic                    hit;
    logic [`CCD_NCH-1:0]     exceed;
    logic [`CCD_RES_W-1:0]   thr_full;

    logic [`CCD_SETTLE_W-1:0] settle_len;
    logic                     settle_zero;
    logic [`CCD_WIN_W-1:0]    win_len;
    logic [`CCD_WIN_W-1:0]    win_cnt;
    logic [`CCD_HITS_W-1:0]   hits_len;
    logic [`CCD_HITS_W-1:0]   hits_cnt;

    wire wr_rsvd = WR_I && (ADDR_I == `CCD_ADDR_RSVD);
    wire wr_cfg  = WR_I && (ADDR_I == `CCD_ADDR_CFG);
    wire wr_thr  = WR_I && (ADDR_I == `CCD_ADDR_THR);
    wire wr_mask = WR_I && (ADDR_I == `CCD_ADDR_MASK);
    wire rd_stat = RD_I && (ADDR_I == `CCD_ADDR_STAT);

    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            rsvd_word <= `CCD_RST_RSVD;
        end else if (wr_rsvd) begin
            rsvd_word <= WDATA_I;
        end
    end

    // config word, reserved bits stored as written
    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            cfg <= ccd_pkg::ccd_cfg_t'(`CCD_RST_CFG);
        end else if (wr_cfg) begin
            cfg <= ccd_pkg::ccd_cfg_t'(WDATA_I);
        end
    end

    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            thr_high <= `CCD_RST_THR;
        end else if (wr_thr) begin
            thr_high <= WDATA_I;
        end
    end

    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            mask <= `CCD_RST_EVT;
        end else if (wr_mask) begin
            mask <= WDATA_I[`CCD_EVT_W-1:0];
        end
    end

    // Read clears, but an event in the same cycle survives
    always_comb begin
        next_status = rd_stat ? `CCD_RST_EVT : status;
        next_status[`CCD_EVT_DETECT] = next_status[`CCD_EVT_DETECT]
                                       | detect_ev;
        next_status[`CCD_EVT_WINDOW] = next_status[`CCD_EVT_WINDOW] | win_end;
    end

    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            status <= `CCD_RST_EVT;
            irq    <= 1'b0;
        end else begin
            status <= next_status;
            irq    <= |(next_status & mask);
        end
    end

    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            rdata <= `CCD_RD_ZERO;
        end else if (RD_I) begin
            case (ADDR_I)
                `CCD_ADDR_RSVD: rdata <= rsvd_word;
                `CCD_ADDR_CFG:  rdata <= cfg;
                `CCD_ADDR_THR:  rdata <= thr_high;
                `CCD_ADDR_STAT: rdata <= {{(`CCD_DATA_W-`CCD_EVT_W){1'b0}},
                                          status};
                `CCD_ADDR_MASK: rdata <= {{(`CCD_DATA_W-`CCD_EVT_W){1'b0}},
                                          mask};
                default:        rdata <= `CCD_RD_ZERO;
            endcase
        end
    end

    // settle wait is 2 shifted left by the code
    assign settle_len = `CCD_SETTLE_BASE << cfg.chop_settle_delay;
    // required exceedances are 1 shifted left by the code
    assign hits_len   = `CCD_HITS_BASE << cfg.detect_hit_count;

    always_comb begin
        case (cfg.detect_window_length)
            3'h0:    win_len = `CCD_LEN_0;
            3'h1:    win_len = `CCD_LEN_1;
            3'h2:    win_len = `CCD_LEN_2;
            3'h3:    win_len = `CCD_LEN_3;
            3'h4:    win_len = `CCD_LEN_4;
            3'h5:    win_len = `CCD_LEN_5;
            3'h6:    win_len = `CCD_LEN_6;
            default: win_len = `CCD_LEN_7;
        endcase
    end

    // low byte of the threshold is fixed at zero
    assign thr_full = {thr_high, `CCD_THR_PAD};

    // Magnitude of two's complement; the most negative code maps to 2^23
    for (genvar ch = 0; ch < `CCD_NCH; ch++) begin : g_cmp
        wire [`CCD_RES_W-1:0] d   = CONV_I.data[ch];
        wire [`CCD_RES_W-1:0] mag = d[`CCD_RES_W-1] ? (~d + 1'b1) : d;
        assign exceed[ch] = (mag > thr_full);
    end

    assign hit = cfg.detect_all_channels ? (&exceed) : (|exceed);
    assign conv_take = CONV_I.valid && (state == ccd_pkg::CCD_MEASURE);

    // chop inserts a settle phase, detect enable runs the engine
    always_comb begin
        next_state  = state;
        load_settle = 1'b0;
        load_win    = 1'b0;
        win_end     = 1'b0;
        detect_ev   = 1'b0;
        case (state)
            ccd_pkg::CCD_IDLE: begin
                if (cfg.detect_enable && cfg.chop_enable) begin
                    load_settle = 1'b1;
                    next_state  = ccd_pkg::CCD_SETTLE;
                end else if (cfg.detect_enable) begin
                    load_win   = 1'b1;
                    next_state = ccd_pkg::CCD_MEASURE;
                end
            end
            ccd_pkg::CCD_SETTLE: begin
                if (settle_zero) begin
                    load_win   = 1'b1;
                    next_state = ccd_pkg::CCD_MEASURE;
                end
            end
            // one detection per window, window ends after its length
            ccd_pkg::CCD_MEASURE: begin
                if (conv_take) begin
                    detect_ev = hit && (hits_cnt == `CCD_HITS_BASE);
                    if (win_cnt == `CCD_WIN_ONE) begin
                        win_end    = 1'b1;
                        next_state = ccd_pkg::CCD_DONE;
                    end
                end
            end
            ccd_pkg::CCD_DONE: begin
                next_state = ccd_pkg::CCD_IDLE;
            end
            default: begin
                next_state = ccd_pkg::CCD_IDLE;
            end
        endcase
        // Disabling detect aborts at once, no event is raised
        if (!cfg.detect_enable) begin
            next_state = ccd_pkg::CCD_IDLE;
            win_end    = 1'b0;
            detect_ev  = 1'b0;
        end
    end

    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            state <= ccd_pkg::CCD_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            detect        <= 1'b0;
            measuring     <= 1'b0;
        end else begin
            detect        <= detect_ev;
            measuring     <= (next_state == ccd_pkg::CCD_MEASURE);
        end
    end

    ccd_down_counter #(.W(`CCD_SETTLE_W)) u_settle (
        .clk_i   (MCLK_I),
        .rst_n_i (RESET_N_I),
        .load_i  (load_settle),
        .value_i (settle_len),
        .dec_i   (MOD_TICK_I && (state == ccd_pkg::CCD_SETTLE)),
        .count_o (),
        .zero_o  (settle_zero)
    );

    // conversion periods left in the window
    ccd_down_counter #(.W(`CCD_WIN_W)) u_window (
        .clk_i   (MCLK_I),
        .rst_n_i (RESET_N_I),
        .load_i  (load_win),
        .value_i (win_len),
        .dec_i   (conv_take),
        .count_o (win_cnt),
        .zero_o  ()
    );

    ccd_down_counter #(.W(`CCD_HITS_W)) u_hits (
        .clk_i   (MCLK_I),
        .rst_n_i (RESET_N_I),
        .load_i  (load_win),
        .value_i (hits_len),
        .dec_i   (conv_take && hit),
        .count_o (hits_cnt),
        .zero_o  ()
    );

    assign RDATA_O       = rdata;
    assign IRQ_O         = irq;
    assign DETECT_O      = detect;
    assign CHOP_ENABLE_O = cfg.chop_enable;
    assign MEASURING_O   = measuring;

    // Helper tallies, read only by the checks below
    logic [`CCD_SETTLE_W-1:0] settle_seen;
    logic [`CCD_SETTLE_W-1:0] settle_want;
    logic [`CCD_WIN_W-1:0]    conv_seen;
    logic [`CCD_WIN_W-1:0]    win_want;
    logic [`CCD_HITS_W-1:0]   hit_seen;
    logic [`CCD_HITS_W-1:0]   hit_want;

    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            settle_seen <= '0;
            settle_want <= '0;
            conv_seen   <= '0;
            win_want    <= '0;
            hit_seen    <= '0;
            hit_want    <= '0;
        end else begin
            if (load_settle) begin
                settle_seen <= '0;
                settle_want <= settle_len;
            end else if (MOD_TICK_I && (state == ccd_pkg::CCD_SETTLE)) begin
                settle_seen <= settle_seen + `CCD_SETTLE_ONE;
            end
            if (load_win) begin
                conv_seen <= '0;
                win_want  <= win_len;
                hit_seen  <= '0;
                hit_want  <= hits_len;
            end else if (conv_take) begin
                conv_seen <= conv_seen + `CCD_WIN_ONE;
                if (hit) begin
                    hit_seen <= hit_seen + `CCD_HITS_BASE;
                end
            end
        end
    end

    a_rsvd_store: assert property (
        @(posedge MCLK_I) disable iff (!RESET_N_I)
        wr_rsvd ##1 !wr_rsvd ##1 (RD_I && ADDR_I == `CCD_ADDR_RSVD && !WR_I)
        |=> RDATA_O == $past(WDATA_I, 3)
    ) else $error("Reserved word readback wrong");

    a_cfg_readback: assert property (
        @(posedge MCLK_I) disable iff (!RESET_N_I)
        (RD_I && ADDR_I == `CCD_ADDR_CFG) |=> RDATA_O == $past(cfg)
    ) else $error("Config readback wrong");

    a_settle_time: assert property (
        @(posedge MCLK_I) disable iff (!RESET_N_I)
        (state == ccd_pkg::CCD_SETTLE && settle_zero)
        |-> settle_seen == settle_want
    ) else $error("Settle wait length wrong");

    a_chop_bypass: assert property (
        @(posedge MCLK_I) disable iff (!RESET_N_I)
        (state == ccd_pkg::CCD_IDLE && cfg.detect_enable && !cfg.chop_enable)
        |=> state == ccd_pkg::CCD_MEASURE ##0 MEASURING_O
    ) else $error("Detect start without chop wrong");

    a_detect_off: assert property (
        @(posedge MCLK_I) disable iff (!RESET_N_I)
        !cfg.detect_enable |=> state == ccd_pkg::CCD_IDLE ##1 !DETECT_O
    ) else $error("Engine runs while disabled");

    a_all_channels: assert property (
        @(posedge MCLK_I) disable iff (!RESET_N_I)
        (conv_take && cfg.detect_all_channels && !(&exceed) && !load_win)
        |=> $stable(hits_cnt)
    ) else $error("Partial hit counted in all mode");

    a_hit_number: assert property (
        @(posedge MCLK_I) disable iff (!RESET_N_I)
        detect_ev |-> (hit_seen + `CCD_HITS_BASE) == hit_want
    ) else $error("Detection at wrong hit count");

    a_window_len: assert property (
        @(posedge MCLK_I) disable iff (!RESET_N_I)
        win_end |-> (conv_seen + `CCD_WIN_ONE) == win_want
    ) else $error("Window length wrong");

    a_below_thr: assert property (
        @(posedge MCLK_I) disable iff (!RESET_N_I)
        (conv_take && exceed == '0 && !load_win) |=> $stable(hits_cnt)
    ) else $error("Hit counted below threshold");

    a_detect_event: assert property (
        @(posedge MCLK_I) disable iff (!RESET_N_I)
        DETECT_O |-> ($past(state) == ccd_pkg::CCD_MEASURE)
                     && status[`CCD_EVT_DETECT]
    ) else $error("Detection outside window");

endmodule

// [testbench/tb_ccd_config_top.sv]
`timescale 1ns/1ps
`include "ccd_defs.svh"

module tb_ccd_config_top;
    // Threshold high word 0010h puts the limit at 00_1000h
    localparam logic [23:0] TH  = 24'h00_1000;
    localparam logic [23:0] HI  = 24'h00_1001;
    localparam logic [23:0] NEG = 24'hFF_EFFF;
    localparam logic [23:0] LO  = 24'h00_0000;

    logic                   MCLK_I;
    logic                   RESET_N_I;
    logic [`CCD_ADDR_W-1:0] ADDR_I;
    logic [`CCD_DATA_W-1:0] WDATA_I;
    logic                   WR_I;
    logic                   RD_I;
    logic [`CCD_DATA_W-1:0] RDATA_O;
    logic                   MOD_TICK_I;
    ccd_pkg::ccd_conv_t     CONV_I;
    logic                   IRQ_O;
    logic                   DETECT_O;
    logic                   CHOP_ENABLE_O;
    logic                   MEASURING_O;
    int                     num_errors;
    int                     total_checks;
    logic [3:0]             rst_addr [6] = '{4'h5, 4'h6, 4'h7,
                                             4'hE, 4'hF, 4'h3};
    logic [15:0]            rst_val [6]  = '{16'h0000, 16'h0600, 16'h0000,
                                             16'h0000, 16'h0000, 16'h0000};
    int                     lens [8] = '{128, 256, 512, 768, 1280, 1792,
                                         2560, 3584};

    ccd_config_top DUT (
        .MCLK_I        (MCLK_I),
        .RESET_N_I     (RESET_N_I),
        .ADDR_I        (ADDR_I),
        .WDATA_I       (WDATA_I),
        .WR_I          (WR_I),
        .RD_I          (RD_I),
        .RDATA_O       (RDATA_O),
        .MOD_TICK_I    (MOD_TICK_I),
        .CONV_I        (CONV_I),
        .IRQ_O         (IRQ_O),
        .DETECT_O      (DETECT_O),
        .CHOP_ENABLE_O (CHOP_ENABLE_O),
        .MEASURING_O   (MEASURING_O)
    );

    initial begin
        MCLK_I = 1'b0;
        forever #10 MCLK_I = ~MCLK_I;
    end

    task automatic give_verdict;
        if (num_errors == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [15:0] got, exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t %s got %b exp %b", $time, msg, got, exp);
        end
    endtask

    // Every access leaves one idle cycle so no strobe is driven twice
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        ADDR_I  <= a;
        WDATA_I <= d;
        WR_I    <= 1'b1;
        @(posedge MCLK_I);
        WR_I <= 1'b0;
        @(posedge MCLK_I);
    endtask

    task automatic rdchk(input logic [3:0] a, input logic [15:0] e);
        ADDR_I <= a;
        RD_I   <= 1'b1;
        @(posedge MCLK_I);
        RD_I <= 1'b0;
        @(negedge MCLK_I);
        chk_word(RDATA_O, e, "read data");
        @(posedge MCLK_I);
    endtask

    task automatic conv(input logic [23:0] a, b, c, input logic det);
        CONV_I.valid   <= 1'b1;
        CONV_I.data[0] <= a;
        CONV_I.data[1] <= b;
        CONV_I.data[2] <= c;
        @(posedge MCLK_I);
        CONV_I.valid <= 1'b0;
        @(negedge MCLK_I);
        chk_bit(DETECT_O, det, "detect pulse");
        @(posedge MCLK_I);
    endtask

    task automatic tick;
        MOD_TICK_I <= 1'b1;
        @(posedge MCLK_I);
        MOD_TICK_I <= 1'b0;
        @(posedge MCLK_I);
    endtask

    task automatic wait_meas;
        int i;
        for (i = 0; i < 64; i++) begin
            @(negedge MCLK_I);
            if (MEASURING_O === 1'b1) break;
        end
        @(posedge MCLK_I);
        if (i == 64) begin
            num_errors++;
            $display("MISMATCH %0t window never started", $time);
            give_verdict();
        end
    endtask

    task automatic stop_det;
        wr(4'h6, 16'h0000);
        @(negedge MCLK_I);
        chk_bit(MEASURING_O, 1'b0, "abort to idle");
        @(posedge MCLK_I);
    endtask

    initial begin
        int c;
        int k;
        num_errors   = 0;
        total_checks = 0;
        RESET_N_I    = 1'b0;
        ADDR_I       = 4'h0;
        WDATA_I      = 16'h0000;
        WR_I         = 1'b0;
        RD_I         = 1'b0;
        MOD_TICK_I   = 1'b0;
        CONV_I       = '0;
        repeat (16) @(posedge MCLK_I);
        RESET_N_I <= 1'b1;
        @(posedge MCLK_I);
        for (c = 0; c < 6; c++) rdchk(rst_addr[c], rst_val[c]);
        chk_bit(CHOP_ENABLE_O, 1'b0, "chop after reset");
        // Reserved top bits kept zero as the host must
        wr(4'h6, 16'h1BBE);
        rdchk(4'h6, 16'h1BBE);
        chk_bit(CHOP_ENABLE_O, 1'b1, "chop on");
        wr(4'h6, 16'h0000);
        chk_bit(CHOP_ENABLE_O, 1'b0, "chop off");
        wr(4'h7, 16'hFFFF);
        rdchk(4'h7, 16'hFFFF);
        wr(4'h5, 16'h0000);
        rdchk(4'h5, 16'h0000);
        wr(4'hF, 16'hFFFF);
        rdchk(4'hF, 16'h0003);
        wr(4'h3, 16'hFFFF);
        rdchk(4'h3, 16'h0000);
        wr(4'hE, 16'hFFFF);
        rdchk(4'hE, 16'h0000);
        wr(4'h7, 16'h0010);
        wr(4'hF, 16'h0001);
        // Any channel, equal to threshold is no hit
        wr(4'h6, 16'h0001);
        wait_meas();
        conv(TH, TH, TH, 1'b0);
        conv(LO, LO, NEG, 1'b1);
        chk_bit(IRQ_O, 1'b1, "irq on detect");
        conv(HI, LO, LO, 1'b0);
        rdchk(4'hE, 16'h0001);
        chk_bit(IRQ_O, 1'b0, "irq after clear");
        stop_det();
        // All channels must exceed together
        wr(4'h6, 16'h0081);
        wait_meas();
        conv(HI, HI, TH, 1'b0);
        conv(NEG, HI, HI, 1'b1);
        stop_det();
        for (c = 0; c < 8; c++) begin
            wr(4'h6, {9'h000, c[2:0], 3'h0, 1'b1});
            wait_meas();
            for (k = 1; k < (1 << c); k++) conv(HI, LO, LO, 1'b0);
            conv(HI, LO, LO, 1'b1);
            stop_det();
        end
        rdchk(4'hE, {14'h0000, 1'b1, 1'b1});
        for (c = 0; c < 8; c++) begin
            wr(4'h6, {12'h000, c[2:0], 1'b1});
            wait_meas();
            for (k = 1; k < lens[c]; k++) conv(LO, LO, LO, 1'b0);
            rdchk(4'hE, 16'h0000);
            conv(LO, LO, LO, 1'b0);
            rdchk(4'hE, 16'h0002);
            chk_bit(IRQ_O, 1'b0, "window event masked");
            stop_det();
        end
        // Settle waits 2 << code modulator ticks
        for (c = 0; c < 12; c++) begin
            wr(4'h6, {3'h0, c[3:0], 1'b1, 8'h01});
            chk_bit(CHOP_ENABLE_O, 1'b1, "chop for settle");
            repeat (3) @(posedge MCLK_I);
            for (k = 1; k < (2 << c); k++) tick();
            repeat (4) @(posedge MCLK_I);
            @(negedge MCLK_I);
            chk_bit(MEASURING_O, 1'b0, "still settling");
            @(posedge MCLK_I);
            tick();
            wait_meas();
            stop_det();
        end
        // Reset in mid-window brings every register back to default
        wr(4'h6, 16'h0001);
        wait_meas();
        RESET_N_I <= 1'b0;
        repeat (2) @(posedge MCLK_I);
        chk_bit(MEASURING_O, 1'b0, "measure in reset");
        chk_bit(IRQ_O, 1'b0, "irq in reset");
        RESET_N_I <= 1'b1;
        @(posedge MCLK_I);
        for (c = 0; c < 6; c++) rdchk(rst_addr[c], rst_val[c]);
        chk_bit(MEASURING_O, 1'b0, "idle after reset");
        chk_bit(CHOP_ENABLE_O, 1'b0, "chop after reset");
        give_verdict();
    end
endmodule
